/* src/rfb_cfg.svh */
// constants of the receive frame buffer readout block
// assumes a single 100 MHz clock, synchronous active-low reset
//
// Contract
// - full buffer write sets both overrun flags
// - internal overrun clears at frame end
// - user overrun clears on clear command
// - overrun frame discarded like reception abort
// - timestamp captured at selected SOF/EOF point
// - timestamp stored via dedicated timestamp pointer
// - auto mode advances pointer per read
// - manual mode advances only by command
// - read pointer holds when buffer empty
// - single and burst reads both accepted
// - RAM address prefetches read pointer plus one
// - format word read loads remaining count
// - further reads decrement count, advance pointer
// - count one to zero decrements frames
// - committed frame increments frame counter
// - commit with last read keeps counter
// - ASIC RAM clock gated when idle
// - aborted frame reverts raw pointer
`ifndef RFB_CFG_SVH
`define RFB_CFG_SVH
`define RFB_ADDR_CTRL 12'h000
`define RFB_ADDR_STAT 12'h004
`define RFB_ADDR_DATA 12'h008
`define RFB_ADDR_TSL 12'h00c
`define RFB_ADDR_TSH 12'h010
`define RFB_ADDR_IRQ 12'h014
`define RFB_ADDR_MASK 12'h018
`define RFB_CTRL_AUTO 0
`define RFB_CTRL_TSEOF 1
`define RFB_CTRL_RESET 32'h0000_0001
`define RFB_CMD_CDO 8
`define RFB_CMD_ADV 9
`define RFB_CMD_REL 10
`define RFB_REMAINING_WORD_COUNT_LSB 0
`define RFB_REMAINING_WORD_COUNT_W 5
`define RFB_TS_OFS 2
`define RFB_META_WORDS 4
`endif

/* src/rfb_pkg.sv */
// types shared by the receive frame buffer readout block
// assumes rfb_cfg.svh supplies numeric constants
package rfb_pkg;
    typedef enum logic [2:0] {
        ST_IDLE, ST_META0, ST_META1, ST_TSZ0, ST_TSZ1, ST_DATA, ST_TSL, ST_TSH
    } rfb_state_t;
    // protocol controller commands, one-cycle pulses
    typedef struct packed {
        logic store_meta;
        logic store_data;
        logic rec_valid;
        logic rec_abort;
        logic sof_sample;
        logic eof_sample;
    } rfb_cmd_t;
    typedef struct packed {
        logic [31:0] meta;
        logic [31:0] ident;
        logic [31:0] data;
    } rfb_wdata_t;
endpackage : rfb_pkg

/* src/rfb_top.sv */
// receive frame buffer with overrun handling, timestamping and apb readout
// assumes protocol controller on the same clock issues one-cycle commands
`timescale 1ns/1ns
`default_nettype none
`include "rfb_cfg.svh"
module rfb_top #(
    parameter int AW = 5,
    parameter int TECH = 0,
    parameter int TSW = 64
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // protocol controller side
    input wire rfb_pkg::rfb_cmd_t pc_cmd,
    input wire rfb_pkg::rfb_wdata_t pc_wdata,
    // external timestamp pin
    input wire logic [TSW-1:0] ts_in,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // status
    output logic irq,
    output logic ram_clk_en
);
    localparam int DEPTH = 1 << AW;
    localparam logic [AW:0] FULLCNT = (AW+1)'(DEPTH);

    // two-stage sync on the pin-sourced timestamp
    logic [TSW-1:0] ts_s1_ff, ts_s2_ff;
    always_ff @(posedge ref_clk) begin
        ts_s1_ff <= ts_in;
        ts_s2_ff <= ts_s1_ff;
    end

    logic [31:0] mem [DEPTH];
    logic [AW-1:0] raw_wp_ff, com_wp_ff, ts_wp_ff, rp_ff;
    logic [AW:0] used_ff, com_used_ff;
    logic [AW:0] frames_ff;
    logic [`RFB_REMAINING_WORD_COUNT_W-1:0] aux_ff;
    logic we_ff;
    logic pslverr_ff, pready_ff;
    logic ovr_int_ff, ovr_usr_ff, rel_pend_ff;
    logic [TSW-1:0] ts_cap_ff;
    logic auto_ff, tseof_ff;
    logic [1:0] irq_st_ff, irq_mask_ff;
    rfb_pkg::rfb_state_t st_ff, nxt_st;
    logic [31:0] ram_q_ff;
    logic [31:0] prdata_ff;

    // apb decode; single-cycle answer
    wire apb_acc = psel & penable;
    wire apb_wr = apb_acc & pwrite;
    wire apb_rd = apb_acc & ~pwrite;
    wire hit_ctrl = paddr == `RFB_ADDR_CTRL;
    wire hit_stat = paddr == `RFB_ADDR_STAT;
    wire hit_data = paddr == `RFB_ADDR_DATA;
    wire hit_tsl = paddr == `RFB_ADDR_TSL;
    wire hit_tsh = paddr == `RFB_ADDR_TSH;
    wire hit_irq = paddr == `RFB_ADDR_IRQ;
    wire hit_mask = paddr == `RFB_ADDR_MASK;
    wire hit_any = hit_ctrl | hit_stat | hit_data | hit_tsl | hit_tsh | hit_irq | hit_mask;
    wire wr_ctrl = apb_wr & hit_ctrl & pstrb[0];
    wire cmd_cdo = apb_wr & hit_ctrl & pstrb[1] & pwdata[`RFB_CMD_CDO];
    wire cmd_adv = apb_wr & hit_ctrl & pstrb[1] & pwdata[`RFB_CMD_ADV];
    wire cmd_rel = apb_wr & hit_ctrl & pstrb[1] & pwdata[`RFB_CMD_REL];

    // read side: auto mode steps on each data read, manual on command
    // only committed words are readable; a frame still being stored stays hidden
    wire empty = com_used_ff == '0;
    wire rd_step = ((apb_rd & hit_data & auto_ff) | (cmd_adv & ~auto_ff)) & ~empty;
    wire in_frame = aux_ff != '0;
    wire last_word = rd_step & in_frame & (aux_ff == `RFB_REMAINING_WORD_COUNT_W'(1));
    wire [AW-1:0] rp_inc = rp_ff + AW'(1);
    // prefetch next word so back-to-back reads see fresh data
    wire [AW-1:0] ram_raddr = rd_step ? rp_inc : rp_ff;

    // storing fsm write path
    logic wr_req;
    logic [31:0] wr_word;
    logic [AW-1:0] wr_addr;
    logic ts_phase;
    wire full = used_ff == FULLCNT;
    wire wr_ok = wr_req & ~full;
    wire ovr_evt = wr_req & full & ~ts_phase;
    wire commit = st_ff == rfb_pkg::ST_TSH;
    wire drop = ovr_int_ff | ovr_evt | rel_pend_ff | cmd_rel;
    wire do_commit = commit & ~drop;
    wire do_abort = (commit & drop) | pc_cmd.rec_abort;

    // next state of the storing fsm
    always_comb begin
        nxt_st = st_ff;
        wr_req = 1'b0;
        wr_word = '0;
        wr_addr = raw_wp_ff;
        ts_phase = 1'b0;
        case (st_ff)
            rfb_pkg::ST_IDLE: begin
                if (pc_cmd.store_meta) begin
                    nxt_st = rfb_pkg::ST_META0;
                end
            end
            rfb_pkg::ST_META0: begin
                wr_req = 1'b1;
                wr_word = pc_wdata.meta;
                nxt_st = rfb_pkg::ST_META1;
            end
            rfb_pkg::ST_META1: begin
                wr_req = 1'b1;
                wr_word = pc_wdata.ident;
                nxt_st = rfb_pkg::ST_TSZ0;
            end
            rfb_pkg::ST_TSZ0: begin
                wr_req = 1'b1;
                nxt_st = rfb_pkg::ST_TSZ1;
            end
            rfb_pkg::ST_TSZ1: begin
                wr_req = 1'b1;
                nxt_st = rfb_pkg::ST_DATA;
            end
            rfb_pkg::ST_DATA: begin
                wr_req = pc_cmd.store_data;
                wr_word = pc_wdata.data;
                if (pc_cmd.rec_valid) begin
                    nxt_st = rfb_pkg::ST_TSL;
                end
            end
            rfb_pkg::ST_TSL: begin
                // timestamp words lie behind the raw pointer
                wr_req = 1'b1;
                ts_phase = 1'b1;
                wr_addr = ts_wp_ff;
                wr_word = ts_cap_ff[31:0];
                nxt_st = rfb_pkg::ST_TSH;
            end
            rfb_pkg::ST_TSH: begin
                wr_req = 1'b1;
                ts_phase = 1'b1;
                wr_addr = ts_wp_ff;
                wr_word = 32'(ts_cap_ff >> 32);
                nxt_st = rfb_pkg::ST_IDLE;
            end
            default: nxt_st = rfb_pkg::ST_IDLE;
        endcase
        if (pc_cmd.rec_abort) begin
            nxt_st = rfb_pkg::ST_IDLE;
        end
    end

    // ts slots reserved at store time, so ts writes bypass the full check;
    // an overrun frame may not own its slots and is dropped anyway, so it writes none
    wire ram_we = ts_phase ? (wr_req & ~ovr_int_ff) : (wr_ok & ~pc_cmd.rec_abort);
    // refresh the output word one cycle after each write; quiet cycles leave the ram alone
    wire ram_re = rd_step | we_ff;
    // asic: gate ram clock when idle; fpga keeps it running
    wire nxt_ram_clk_en = (TECH == 0) ? (ram_we | ram_re) : 1'b1;

    // ram write and registered read
    always_ff @(posedge ref_clk) begin
        if (ram_we) begin
            mem[wr_addr] <= wr_word;
        end
        if (ram_re) begin
            ram_q_ff <= mem[ram_raddr];
        end
    end

    // fsm, pointers, occupancy
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            st_ff <= rfb_pkg::ST_IDLE;
            we_ff <= 1'b0;
            raw_wp_ff <= '0;
            com_wp_ff <= '0;
            ts_wp_ff <= '0;
            used_ff <= '0;
            com_used_ff <= '0;
        end else begin
            st_ff <= nxt_st;
            we_ff <= ram_we;
            if (do_abort) begin
                raw_wp_ff <= com_wp_ff;
                used_ff <= com_used_ff - (AW+1)'(rd_step);
            end else begin
                if (wr_ok & ~ts_phase) begin
                    raw_wp_ff <= raw_wp_ff + AW'(1);
                end
                used_ff <= used_ff + (AW+1)'(wr_ok & ~ts_phase) - (AW+1)'(rd_step);
            end
            if (st_ff == rfb_pkg::ST_META1) begin
                ts_wp_ff <= raw_wp_ff + AW'(1);
            end else if (st_ff == rfb_pkg::ST_TSL) begin
                ts_wp_ff <= ts_wp_ff + AW'(1);
            end
            if (do_commit) begin
                com_wp_ff <= raw_wp_ff;
                com_used_ff <= used_ff - (AW+1)'(rd_step);
            end else begin
                com_used_ff <= com_used_ff - (AW+1)'(rd_step);
            end
        end
    end

    // read pointer and auxiliary word counter
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            rp_ff <= '0;
            aux_ff <= '0;
        end else if (rd_step) begin
            rp_ff <= rp_inc;
            if (in_frame) begin
                aux_ff <= aux_ff - `RFB_REMAINING_WORD_COUNT_W'(1);
            end else begin
                aux_ff <= ram_q_ff[`RFB_REMAINING_WORD_COUNT_LSB +: `RFB_REMAINING_WORD_COUNT_W];
            end
        end
    end

    // frame counter; commit and last read together cancel
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            frames_ff <= '0;
        end else if (do_commit & ~last_word) begin
            frames_ff <= frames_ff + (AW+1)'(1);
        end else if (last_word & ~do_commit) begin
            frames_ff <= frames_ff - (AW+1)'(1);
        end
    end

    // overrun flags, set wins over clear; release-pending flag, clear wins over set
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            ovr_int_ff <= 1'b0;
            ovr_usr_ff <= 1'b0;
            rel_pend_ff <= 1'b0;
        end else begin
            if (ovr_evt) begin
                ovr_int_ff <= 1'b1;
            end else if (commit | pc_cmd.rec_abort) begin
                ovr_int_ff <= 1'b0;
            end
            if (ovr_evt) begin
                ovr_usr_ff <= 1'b1;
            end else if (cmd_cdo) begin
                ovr_usr_ff <= 1'b0;
            end
            if (commit | pc_cmd.rec_abort) begin
                rel_pend_ff <= 1'b0;
            end else if (cmd_rel & (st_ff != rfb_pkg::ST_IDLE)) begin
                rel_pend_ff <= 1'b1;
            end
        end
    end

    // timestamp capture at chosen bit
    wire ts_take = tseof_ff ? pc_cmd.eof_sample : pc_cmd.sof_sample;
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            ts_cap_ff <= '0;
        end else if (ts_take) begin
            ts_cap_ff <= ts_s2_ff;
        end
    end

    // control, interrupt status (read clears) and mask
    wire [1:0] irq_evt = {do_commit, ovr_evt};
    wire irq_rd_clr = apb_rd & hit_irq;
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            auto_ff <= 1'(`RFB_CTRL_RESET >> `RFB_CTRL_AUTO);
            tseof_ff <= 1'b0;
            irq_st_ff <= '0;
            irq_mask_ff <= '0;
        end else begin
            if (wr_ctrl) begin
                auto_ff <= pwdata[`RFB_CTRL_AUTO];
                tseof_ff <= pwdata[`RFB_CTRL_TSEOF];
            end
            irq_st_ff <= (irq_rd_clr ? 2'h0 : irq_st_ff) | irq_evt;
            if (apb_wr & hit_mask & pstrb[0]) begin
                irq_mask_ff <= pwdata[1:0];
            end
        end
    end

    // read data mux
    wire [31:0] stat_word = {16'h0, 7'h0, ovr_usr_ff, 2'h0, 6'(frames_ff)};
    wire [31:0] rd_mux = hit_ctrl ? {30'h0, tseof_ff, auto_ff} :
                         hit_stat ? stat_word :
                         hit_data ? ram_q_ff :
                         hit_tsl ? ts_cap_ff[31:0] :
                         hit_tsh ? 32'(ts_cap_ff >> 32) :
                         hit_irq ? {30'h0, irq_st_ff} :
                         hit_mask ? {30'h0, irq_mask_ff} : 32'h0;

    // registered outputs; error decided in setup so it stands through the access
    always_ff @(posedge ref_clk) begin
        pready_ff <= 1'b1; // zero wait states, also during reset
        if (!rst_b) begin
            prdata_ff <= '0;
            pslverr_ff <= 1'b0;
            irq <= 1'b0;
            ram_clk_en <= 1'b0;
        end else begin
            prdata_ff <= (psel & ~penable & ~pwrite) ? rd_mux : prdata_ff;
            pslverr_ff <= psel & ~penable & ~hit_any;
            irq <= |(irq_st_ff & irq_mask_ff);
            ram_clk_en <= nxt_ram_clk_en;
        end
    end

    // apb answers in the access cycle straight from the flops
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
endmodule : rfb_top
`default_nettype wire

/* sim/rfb_top_props.sv */
// port assertions for the receive frame buffer
// assumes binding into rfb_top; one clock, sync active-low reset
`timescale 1ns/1ns
`default_nettype none
module rfb_top_props #(
    parameter int AW = 5,
    parameter int TECH = 0,
    parameter int TSW = 64
) (
    // watched ports
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire rfb_pkg::rfb_cmd_t pc_cmd,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq,
    input wire logic ram_clk_en
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    logic [3:0] idle_ff;
    logic acc;
    logic bad;
    // access phase and unmapped decode
    assign acc = psel && penable;
    assign bad = paddr > 12'h018;
    // quiet cycles, long enough to outlast storing and prefetch
    always_ff @(posedge ref_clk) begin
        if (!rst_b || pc_cmd != '0 || psel) idle_ff <= 4'h0;
        else if (idle_ff != 4'hf) idle_ff <= idle_ff + 4'h1;
    end
    zero_wait_a: assert property (acc |-> pready) else $error("access not ready");
    err_unmapped_a: assert property (acc && bad |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped not refused");
    err_mapped_a: assert property (acc && !bad && paddr[1:0] == 2'b00 |-> !pslverr) else $error("mapped refused");
    rdata_hold_a: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata)) else $error("rdata moved");
    meta_gate_a: assert property (TECH == 0 && pc_cmd.store_meta |-> ##[1:3] ram_clk_en)
        else $error("ram clock off in store");
    // a word refused at overrun is no ram write; the overrun shows on irq instead
    data_gate_a: assert property (TECH == 0 && pc_cmd.store_data |-> ##[1:3] (ram_clk_en || irq))
        else $error("ram clock off in store");
    idle_gate_a: assert property (TECH == 0 && idle_ff == 4'hf |-> !ram_clk_en)
        else $error("ram clock on while idle");
    mask_off_a: assert property (acc && pwrite && paddr == 12'h018 && pwdata == 32'h0 |-> ##2 !irq)
        else $error("irq while masked");
    // main scenarios
    burst_c: cover property (acc && paddr == 12'h008 ##2 acc && paddr == 12'h008);
    irq_c: cover property ($rose(irq));
    refuse_c: cover property (acc && pslverr);
endmodule : rfb_top_props
bind rfb_top rfb_top_props #(.AW(AW), .TECH(TECH), .TSW(TSW)) i_rfb_top_props (.ref_clk(ref_clk), .rst_b(rst_b),
    .pc_cmd(pc_cmd), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .ram_clk_en(ram_clk_en));
`default_nettype wire

/* sim/rfb_pc_model.sv */
// protocol controller stand-in issuing the storing commands
// assumes the buffer's clock; notes committed words in wq
`timescale 1ns/1ns
`default_nettype none
module rfb_pc_model (
    // clock
    input wire logic ref_clk,
    // storing side
    output var rfb_pkg::rfb_cmd_t pc_cmd,
    output var rfb_pkg::rfb_wdata_t pc_wdata,
    output logic [63:0] ts_in
);
    logic [31:0] wq[$];
    // quiet until the first frame
    initial begin
        pc_cmd = '0;
        pc_wdata = '0;
        ts_in = 64'h0;
    end
    // one-cycle command plus a gap so pulses never merge
    task automatic pulse(input int k);
        pc_cmd <= rfb_pkg::rfb_cmd_t'(6'h1 << k);
        @(posedge ref_clk);
        pc_cmd <= '0;
        @(posedge ref_clk);
    endtask : pulse
    // one frame of nd data words; stamp moves after sof so the position shows
    task automatic frame(input int nd, input bit ab, input bit keep, input bit eof);
        logic [63:0] t;
        logic [31:0] w[$];
        t = {$urandom, $urandom};
        w.push_back(32'(nd + 3));
        w.push_back($urandom);
        w.push_back(eof ? ~t[31:0] : t[31:0]);
        w.push_back(eof ? ~t[63:32] : t[63:32]);
        ts_in <= t;
        pc_wdata.meta <= w[0];
        pc_wdata.ident <= w[1];
        repeat (3) @(posedge ref_clk);
        pulse(1);
        ts_in <= ~t;
        pulse(5);
        repeat (4) @(posedge ref_clk);
        for (int i = 0; i < nd; i++) begin
            w.push_back($urandom);
            pc_wdata.data <= w[i + 4];
            pulse(4);
        end
        pulse(ab ? 2 : 0);
        if (!ab) pulse(3);
        pc_wdata <= ~pc_wdata;
        repeat (4) @(posedge ref_clk);
        if (keep && !ab) wq = {wq, w};
    endtask : frame
endmodule : rfb_pc_model
`default_nettype wire

/* sim/tb_top.sv */
// self-checking bench for the receive frame buffer readout
// assumes rfb_pc_model drives the storing side
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, irq, ram_clk_en;
    rfb_pkg::rfb_cmd_t pc_cmd;
    rfb_pkg::rfb_wdata_t pc_wdata;
    logic [63:0] ts_in;
    logic [33:0] exq[$];
    int errors = 0;
    int compares = 0;
    // 100 MHz clock
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    rfb_top i_rfb_top (.ref_clk(ref_clk), .rst_b(rst_b), .pc_cmd(pc_cmd), .pc_wdata(pc_wdata), .ts_in(ts_in),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .ram_clk_en(ram_clk_en));
    rfb_pc_model i_rfb_pc_model (.ref_clk(ref_clk), .pc_cmd(pc_cmd), .pc_wdata(pc_wdata), .ts_in(ts_in));
    task automatic cmp(input logic [32:0] g, input logic [32:0] e);
        compares++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask : cmp
    task automatic end_of_test();
        if (errors == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test
    // setup, access until pready; a release costs one idle edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input bit last);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        if (last) begin
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge ref_clk);
        end
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 1'b1);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e, input bit ign = 1'b0, input bit last = 1'b1);
        exq.push_back({ign, a > 12'h018, e});
        apb(1'b0, a, 32'h0, last);
    endtask : rd
    task automatic drain(input int n);
        for (int i = 0; i < n; i++) rd(12'h008, i_rfb_pc_model.wq.pop_front(), 1'b0, i == n - 1);
    endtask : drain
    // each finished read meets its oldest note
    always @(posedge ref_clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && exq.size() > 0) begin
            if (!exq[0][33]) cmp({pslverr, prdata}, exq[0][32:0]);
            void'(exq.pop_front());
        end
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        end_of_test();
    end
    initial begin
        logic [31:0] e;
        void'($urandom(16030));
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        rd(12'h000, 32'h1);
        rd(12'h004, 32'h0);
        rd(12'h01c, 32'h0);
        wr(12'h018, 32'h3);
        i_rfb_pc_model.frame(2, 1'b0, 1'b1, 1'b0);
        repeat (20) @(posedge ref_clk);
        cmp({32'h0, irq}, 33'h1);
        rd(12'h004, 32'h1);
        rd(12'h014, 32'h2);
        rd(12'h014, 32'h0);
        drain(6);
        rd(12'h004, 32'h0);
        cmp({32'h0, irq}, 33'h0);
        rd(12'h008, 32'h0, 1'b1);
        wr(12'h000, 32'h2);
        i_rfb_pc_model.frame(1, 1'b0, 1'b1, 1'b1);
        for (int i = 0; i < 5; i++) begin
            e = i_rfb_pc_model.wq.pop_front();
            rd(12'h008, e, 1'b0, 1'b0);
            rd(12'h008, e);
            wr(12'h000, 32'h202);
        end
        rd(12'h004, 32'h0);
        wr(12'h000, 32'h1);
        i_rfb_pc_model.frame(3, 1'b1, 1'b0, 1'b0);
        rd(12'h004, 32'h0);
        // release command lands while the frame is being stored
        fork
            i_rfb_pc_model.frame(1, 1'b0, 1'b0, 1'b0);
            begin
                repeat (8) @(posedge ref_clk);
                wr(12'h000, 32'h401);
            end
        join
        rd(12'h004, 32'h0);
        i_rfb_pc_model.frame(0, 1'b0, 1'b1, 1'b0);
        drain(4);
        repeat (3) i_rfb_pc_model.frame(4, 1'b0, 1'b1, 1'b0);
        i_rfb_pc_model.frame(12, 1'b0, 1'b0, 1'b0);
        cmp({32'h0, irq}, 33'h1);
        rd(12'h004, 32'h103);
        wr(12'h018, 32'h0);
        rd(12'h014, 32'h3);
        wr(12'h000, 32'h101);
        rd(12'h004, 32'h3);
        drain(24);
        i_rfb_pc_model.frame(1, 1'b0, 1'b1, 1'b0);
        rd(12'h004, 32'h1);
        drain(5);
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
